//--- common/io_line_consts.svh
// Register offsets, reset values and sizes for the I/O line direction block
`ifndef IO_LINE_CONSTS_SVH
`define IO_LINE_CONSTS_SVH
`define NUM_GIO 96
`define NUM_MFC 16
`define NUM_DCON 40
`define NUM_TRIG 8
`define NUM_LB 13
// Byte offsets of the registers (one aligned word each)
`define OFS_GIO_DIR0 12'h000
`define OFS_GIO_DIR1 12'h004
`define OFS_GIO_DIR2 12'h008
`define OFS_GIO_OUT0 12'h00c
`define OFS_GIO_OUT1 12'h010
`define OFS_GIO_OUT2 12'h014
`define OFS_GIO_IN0 12'h018
`define OFS_GIO_IN1 12'h01c
`define OFS_GIO_IN2 12'h020
`define OFS_TRIG_CTL 12'h024
`define OFS_LB_DIR 12'h028
`define OFS_LB_OUT 12'h02c
`define OFS_LINE_IN 12'h030
`define OFS_CONFIG 12'h034
// Direction resets: every line an input
`define DIR_RESET 32'h0000_0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

//--- common/io_line_pkg.sv
// Types shared by the I/O line direction block
package io_line_pkg;
   typedef struct packed {
      logic [95:0] oe;
      logic [95:0] dout;
   } gio_drive_s;
   typedef struct packed {
      logic [7:0] trigOe;
      logic [7:0] trigOut;
      logic starOe;
      logic starOut;
      logic [12:0] lbrOe;
      logic [12:0] lbrOut;
      logic [12:0] lblOe;
      logic [12:0] lblOut;
   } bus_drive_s;
   typedef enum logic [1:0] {
      rdIdle,
      rdResp
   } rd_state_e;
   typedef enum logic [1:0] {
      wrIdle,
      wrResp
   } wr_state_e;
endpackage : io_line_pkg

//--- hw/line_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
`include "io_line_consts.svh"
module line_sync #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_s;
   sync_s st_q;
   sync_s st_d;

   // First stage is read by the second only
   always_comb begin
      st_d = st_q;
      if (ce) begin
         st_d.meta = din;
         st_d.stable = st_q.meta;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign dout = st_q.stable;
endmodule : line_sync

//--- hw/line_driver.sv
// Registered tri-state pin driver: enable and value per line
`timescale 1ns/10ps
`include "io_line_consts.svh"
module line_driver #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [W-1:0] dirOut,
   input wire logic [W-1:0] val,
   output logic [W-1:0] pinOe,
   output logic [W-1:0] pinOut
);
   typedef struct packed {
      logic [W-1:0] oe;
      logic [W-1:0] o;
   } drv_s;
   drv_s st_q;
   drv_s st_d;

   // Value is forced low while undriven so nothing leaks out on enable
   always_comb begin
      st_d = st_q;
      if (ce) begin
         st_d.oe = dirOut;
         st_d.o = val & dirOut;
      end
   end

   // Reset leaves every pin released
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pinOe = st_q.oe;
   assign pinOut = st_q.o;
endmodule : line_driver

//--- hw/io_and_trigger_line_direction.sv
// Direction and drive control for general I/O, trigger and local bus lines
// Overview of operation
// - There are 96 two-way general lines: 16 on the multifunction connector and 40 on each digital connector.
// - Each general line has its own direction bit, free of all others.
// - After reset every general line is released (not driven).
// - Directions may be mixed within one port, e.g. lines 0-3 in, 4-7 out.
// - The eight shared trigger lines can both send and receive.
// - Desktop variant: seven trigger lines and one oscillator line; backplane variant: eight.
// - Each shared trigger line has its own direction bit.
// - Only one instrument drives a shared trigger line; the others keep it as input.
// - The backplane variant has a star trigger line to or from the first peripheral slot.
// - The backplane variant has left and right local buses of 13 lines each.
// - Right line n goes to left line n of the right-hand neighbour.
// - Each local bus line has its own direction bit.
// - Only one party drives a local bus line; the neighbour keeps it as input.
// - In the first peripheral slot the 13 left lines are separate star triggers to slots 3-15.
// - The device and another party never drive the same star trigger line together.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "io_line_consts.svh"
module io_and_trigger_line_direction (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // AXI4-Lite slave
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // General lines: 0-15 connector 0, 16-55 connector 1, 56-95 connector 2
   input wire logic [95:0] generalIoLineIn,
   output logic [95:0] generalIoLineOut,
   output logic [95:0] generalIoLineOe,
   // Shared trigger lines; bit 7 is the oscillator line on desktop variant
   input wire logic [7:0] sharedTriggerLineIn,
   output logic [7:0] sharedTriggerLineOut,
   output logic [7:0] sharedTriggerLineOe,
   input wire logic starIn,
   output logic starOut,
   output logic starOe,
   input wire logic [12:0] lbRightIn,
   output logic [12:0] lbRightOut,
   output logic [12:0] lbRightOe,
   input wire logic [12:0] lbLeftIn,
   output logic [12:0] lbLeftOut,
   output logic [12:0] lbLeftOe
);
   typedef struct packed {
      logic [95:0] gioDir;
      logic [95:0] gioVal;
      logic [7:0] trigDir;
      logic [7:0] trigVal;
      logic starDir;
      logic starVal;
      logic [12:0] lbrDir;
      logic [12:0] lbrVal;
      logic [12:0] lblDir;
      logic [12:0] lblVal;
      logic backplane;
      logic firstSlot;
      io_line_pkg::wr_state_e wrSt;
      logic awHeld;
      logic [11:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic [1:0] bResp;
      io_line_pkg::rd_state_e rdSt;
      logic [31:0] rData;
      logic [1:0] rResp;
   } state_s;
   state_s st_q;
   state_s st_d;

   logic [95:0] gioInSync;
   logic [7:0] trigInSync;
   logic starInSync;
   logic [12:0] lbrInSync;
   logic [12:0] lblInSync;

   // Byte-lane merge used by every writable register
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Pin inputs cross into the clock domain through two flops
   line_sync #(.W(`NUM_GIO)) uSyncGio (
      .clk(clk), .rstn(rstn), .ce(ce),
      .din(generalIoLineIn), .dout(gioInSync));
   line_sync #(.W(`NUM_TRIG + 1 + 2 * `NUM_LB)) uSyncBus (
      .clk(clk), .rstn(rstn), .ce(ce),
      .din({sharedTriggerLineIn, starIn, lbRightIn, lbLeftIn}),
      .dout({trigInSync, starInSync, lbrInSync, lblInSync}));

   logic [95:0] gioOeSel;
   logic [7:0] trigOeSel;
   logic starOeSel;
   logic [12:0] lbrOeSel;
   logic [12:0] lblOeSel;

   // Only lines explicitly set to output drive; variant gates backplane pins
   always_comb begin
      gioOeSel = st_q.gioDir;
      trigOeSel = st_q.trigDir;
      starOeSel = st_q.starDir & st_q.backplane;
      lbrOeSel = st_q.lbrDir & {`NUM_LB{st_q.backplane}};
      lblOeSel = st_q.lblDir & {`NUM_LB{st_q.backplane}};
   end

   // All 96 general lines, each with its own enable
   line_driver #(.W(`NUM_GIO)) uDrvGio (
      .clk(clk), .rstn(rstn), .ce(ce),
      .dirOut(gioOeSel), .val(st_q.gioVal),
      .pinOe(generalIoLineOe), .pinOut(generalIoLineOut));
   line_driver #(.W(`NUM_TRIG + 1 + 2 * `NUM_LB)) uDrvBus (
      .clk(clk), .rstn(rstn), .ce(ce),
      .dirOut({trigOeSel, starOeSel, lbrOeSel, lblOeSel}),
      .val({st_q.trigVal, st_q.starVal, st_q.lbrVal, st_q.lblVal}),
      .pinOe({sharedTriggerLineOe, starOe, lbRightOe, lbLeftOe}),
      .pinOut({sharedTriggerLineOut, starOut, lbRightOut,
               lbLeftOut}));

   // Bus slave: write path then read path
   always_comb begin
      logic [11:0] a;
      logic [31:0] v;
      a = '0;
      v = '0;
      st_d = st_q;
      if (ce) begin
         // Address and data are taken in either order
         if (awvalid && !st_q.awHeld && st_q.wrSt == io_line_pkg::wrIdle) begin
            st_d.awHeld = 1'b1;
            st_d.awAddr = awaddr;
         end
         if (wvalid && !st_q.wHeld && st_q.wrSt == io_line_pkg::wrIdle) begin
            st_d.wHeld = 1'b1;
            st_d.wData = wdata;
            st_d.wStrb = wstrb;
         end
         if (st_q.awHeld && st_q.wHeld && st_q.wrSt == io_line_pkg::wrIdle) begin
            a = {st_q.awAddr[11:2], 2'b00};
            st_d.bResp = `RESP_OKAY;
            // Parallel-tied outputs stay equal because one word updates
            // the byte lanes that wstrb selects in a register at one edge
            if (a == `OFS_GIO_DIR0) begin
               st_d.gioDir[31:0] = merge(st_q.gioDir[31:0], st_q.wData,
                                         st_q.wStrb);
            end else if (a == `OFS_GIO_DIR1) begin
               st_d.gioDir[63:32] = merge(st_q.gioDir[63:32], st_q.wData,
                                          st_q.wStrb);
            end else if (a == `OFS_GIO_DIR2) begin
               st_d.gioDir[95:64] = merge(st_q.gioDir[95:64], st_q.wData,
                                          st_q.wStrb);
            end else if (a == `OFS_GIO_OUT0) begin
               st_d.gioVal[31:0] = merge(st_q.gioVal[31:0], st_q.wData,
                                         st_q.wStrb);
            end else if (a == `OFS_GIO_OUT1) begin
               st_d.gioVal[63:32] = merge(st_q.gioVal[63:32], st_q.wData,
                                          st_q.wStrb);
            end else if (a == `OFS_GIO_OUT2) begin
               st_d.gioVal[95:64] = merge(st_q.gioVal[95:64], st_q.wData,
                                          st_q.wStrb);
            end else if (a == `OFS_TRIG_CTL) begin
               v = merge({6'h00, st_q.starVal, st_q.starDir, 8'h00,
                          st_q.trigVal, st_q.trigDir}, st_q.wData, st_q.wStrb);
               st_d.trigDir = v[7:0];
               st_d.trigVal = v[15:8];
               st_d.starDir = v[24];
               st_d.starVal = v[25];
            end else if (a == `OFS_LB_DIR) begin
               v = merge({3'h0, st_q.lblDir, 3'h0, st_q.lbrDir},
                         st_q.wData, st_q.wStrb);
               st_d.lbrDir = v[12:0];
               st_d.lblDir = v[28:16];
            end else if (a == `OFS_LB_OUT) begin
               v = merge({3'h0, st_q.lblVal, 3'h0, st_q.lbrVal},
                         st_q.wData, st_q.wStrb);
               st_d.lbrVal = v[12:0];
               st_d.lblVal = v[28:16];
            end else if (a == `OFS_CONFIG) begin
               v = merge({30'h0, st_q.firstSlot, st_q.backplane},
                         st_q.wData, st_q.wStrb);
               st_d.backplane = v[0];
               st_d.firstSlot = v[1];
            end else if (a == `OFS_GIO_IN0 || a == `OFS_GIO_IN1 ||
                         a == `OFS_GIO_IN2 || a == `OFS_LINE_IN) begin
               st_d.bResp = `RESP_OKAY; // Read-only: write ignored
            end else begin
               st_d.bResp = `RESP_SLVERR;
            end
            st_d.awHeld = 1'b0;
            st_d.wHeld = 1'b0;
            st_d.wrSt = io_line_pkg::wrResp;
         end
         if (st_q.wrSt == io_line_pkg::wrResp && bready) begin
            st_d.wrSt = io_line_pkg::wrIdle;
         end
         // Read path: one-cycle answer after the address is taken
         if (st_q.rdSt == io_line_pkg::rdIdle && arvalid) begin
            a = {araddr[11:2], 2'b00};
            st_d.rResp = `RESP_OKAY;
            st_d.rData = '0;
            if (a == `OFS_GIO_DIR0) begin
               st_d.rData = st_q.gioDir[31:0];
            end else if (a == `OFS_GIO_DIR1) begin
               st_d.rData = st_q.gioDir[63:32];
            end else if (a == `OFS_GIO_DIR2) begin
               st_d.rData = st_q.gioDir[95:64];
            end else if (a == `OFS_GIO_OUT0) begin
               st_d.rData = st_q.gioVal[31:0];
            end else if (a == `OFS_GIO_OUT1) begin
               st_d.rData = st_q.gioVal[63:32];
            end else if (a == `OFS_GIO_OUT2) begin
               st_d.rData = st_q.gioVal[95:64];
            end else if (a == `OFS_GIO_IN0) begin
               st_d.rData = gioInSync[31:0];
            end else if (a == `OFS_GIO_IN1) begin
               st_d.rData = gioInSync[63:32];
            end else if (a == `OFS_GIO_IN2) begin
               st_d.rData = gioInSync[95:64];
            end else if (a == `OFS_TRIG_CTL) begin
               st_d.rData = {6'h00, st_q.starVal, st_q.starDir, 8'h00,
                             st_q.trigVal, st_q.trigDir};
            end else if (a == `OFS_LB_DIR) begin
               st_d.rData = {3'h0, st_q.lblDir, 3'h0, st_q.lbrDir};
            end else if (a == `OFS_LB_OUT) begin
               st_d.rData = {3'h0, st_q.lblVal, 3'h0, st_q.lbrVal};
            end else if (a == `OFS_LINE_IN) begin
               // Left lines 10-12 do not fit this word and are not readable
               st_d.rData = {lblInSync[9:6], starInSync, lbrInSync,
                             lblInSync[5:0], trigInSync};
            end else if (a == `OFS_CONFIG) begin
               st_d.rData = {30'h0, st_q.firstSlot, st_q.backplane};
            end else begin
               st_d.rResp = `RESP_SLVERR;
            end
            st_d.rdSt = io_line_pkg::rdResp;
         end else if (st_q.rdSt == io_line_pkg::rdResp && rready) begin
            st_d.rdSt = io_line_pkg::rdIdle;
         end
      end
   end

   // Directions clear at reset so nothing drives until software asks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
         st_q.wrSt <= io_line_pkg::wrIdle;
         st_q.rdSt <= io_line_pkg::rdIdle;
      end else begin
         st_q <= st_d;
      end
   end

   // Handshake outputs straight from state flops
   always_comb begin
      awready = ~st_q.awHeld & (st_q.wrSt == io_line_pkg::wrIdle);
      wready = ~st_q.wHeld & (st_q.wrSt == io_line_pkg::wrIdle);
      bvalid = st_q.wrSt == io_line_pkg::wrResp;
      bresp = st_q.bResp;
      arready = st_q.rdSt == io_line_pkg::rdIdle;
      rvalid = st_q.rdSt == io_line_pkg::rdResp;
      rdata = st_q.rData;
      rresp = st_q.rResp;
   end

   a_gio_released: assert property (@(posedge clk) disable iff (!rstn)
      $rose(rstn) |-> generalIoLineOe == '0)
      else $error("general lines driven right after reset");
   a_gio_follow: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> generalIoLineOe == $past(st_q.gioDir))
      else $error("general enable does not follow direction");
   a_trig_follow: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> sharedTriggerLineOe == $past(st_q.trigDir))
      else $error("trigger enable does not follow direction");
   a_trig_input: assert property (@(posedge clk) disable iff (!rstn)
      (ce && st_q.trigDir == '0) |=> sharedTriggerLineOe == '0)
      else $error("trigger driven while configured input");
   a_star_gate: assert property (@(posedge clk) disable iff (!rstn)
      (ce && !st_q.backplane) |=> !starOe)
      else $error("star driven on desktop variant");
   a_lb_gate: assert property (@(posedge clk) disable iff (!rstn)
      (ce && !st_q.backplane) |=> (lbRightOe == '0 && lbLeftOe == '0))
      else $error("local bus driven on desktop variant");
   a_lbr_follow: assert property (@(posedge clk) disable iff (!rstn)
      (ce && st_q.backplane) |=> lbRightOe == $past(st_q.lbrDir))
      else $error("right bus enable wrong");
   a_lbl_follow: assert property (@(posedge clk) disable iff (!rstn)
      (ce && st_q.backplane) |=> lbLeftOe == $past(st_q.lblDir))
      else $error("left bus enable wrong");
   a_undriven_low: assert property (@(posedge clk) disable iff (!rstn)
      (lbRightOut & ~lbRightOe) == '0)
      else $error("value on released right bus line");
   a_bus_answer: assert property (@(posedge clk) disable iff (!rstn)
      (ce && arvalid && arready) |=> rvalid)
      else $error("read not answered in one cycle");
   c_write_done: cover property (@(posedge clk) bvalid && bready);
   c_read_done: cover property (@(posedge clk) rvalid && rready);
   c_trig_drive: cover property (@(posedge clk) sharedTriggerLineOe != '0);
   c_lb_drive: cover property (@(posedge clk) lbLeftOe != '0);
endmodule : io_and_trigger_line_direction

//--- test/line_partner.sv
// Model of the external equipment and neighbouring slots on every line
`timescale 1ns/10ps
module line_partner #(
   parameter int W = 131
) (
   input wire logic clk,
   input wire logic [W-1:0] devOe,
   input wire logic [W-1:0] devOut,
   input wire logic [W-1:0] farDrv,
   input wire logic [W-1:0] farVal,
   output logic [W-1:0] lineLvl
);
   logic [W-1:0] floatQ = '0;
   logic [W-1:0] farOe;

   // Far side keeps a line as input while this device drives it
   assign farOe = farDrv & ~devOe;

   // Undriven lines wander every cycle, so a stale level never looks valid
   always @(posedge clk) begin
      floatQ <= ~lineLvl;
   end

   // Wire level worked out from the enables of both parties
   assign lineLvl = (devOe & devOut) | (farOe & farVal)
                    | (~devOe & ~farOe & floatQ);
endmodule : line_partner

//--- test/io_and_trigger_line_direction_tb_top.sv
// Self-checking bench for the line direction and drive block
`timescale 1ns/10ps
`include "io_line_consts.svh"
module io_and_trigger_line_direction_tb_top;
   logic clk, rstn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, starOut, starOe;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [95:0] gOut, gOe;
   logic [7:0] tOut, tOe;
   logic [12:0] rOut, rOe, lOut, lOe;
   logic [130:0] farDrv, farVal;
   wire logic [130:0] lvl;
   int nErrors, testsRun;

   // Pin map: general [130:35], trigger [34:27], star [26], right, left
   line_partner #(.W(131)) far (
      .clk(clk),
      .devOe({gOe, tOe, starOe, rOe, lOe}),
      .devOut({gOut, tOut, starOut, rOut, lOut}),
      .farDrv(farDrv),
      .farVal(farVal),
      .lineLvl(lvl)
   );

   io_and_trigger_line_direction uut (
      .clk(clk), .rstn(rstn), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .generalIoLineIn(lvl[130:35]), .generalIoLineOut(gOut),
      .generalIoLineOe(gOe), .sharedTriggerLineIn(lvl[34:27]),
      .sharedTriggerLineOut(tOut), .sharedTriggerLineOe(tOe),
      .starIn(lvl[26]), .starOut(starOut), .starOe(starOe),
      .lbRightIn(lvl[25:13]), .lbRightOut(rOut), .lbRightOe(rOe),
      .lbLeftIn(lvl[12:0]), .lbLeftOut(lOut), .lbLeftOe(lOe)
   );

   // Free-running 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic testDone();
      $display("Checks %0d, mismatches %0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : testDone

   task automatic check(input string what, input logic [95:0] seen,
                        input logic [95:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nErrors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // A wait that runs out counts as a mismatch and ends the run
   task automatic hang();
      nErrors++;
      $display("MISMATCH handshake timeout");
      testDone();
   endtask : hang

   // Address and data offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] er);
      int n;
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (!aw && awready) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            bready <= 1'b0;
            check("bresp", 96'(bresp), 96'(er));
            break;
         end
         n++;
         if (n > 50) hang();
      end
   endtask : wr

   // Read one word, compare masked data and the response code
   task automatic rdChk(input string what, input logic [11:0] a,
                        input logic [31:0] m, input logic [31:0] exp,
                        input logic [1:0] er);
      int n;
      logic ar;
      ar = 1'b0;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (!ar && arready) begin
            ar = 1'b1;
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            rready <= 1'b0;
            check(what, 96'(rdata & m), 96'(exp));
            check("rresp", 96'(rresp), 96'(er));
            break;
         end
         n++;
         if (n > 50) hang();
      end
   endtask : rdChk

   // Register, then pin flop: pins follow a write within a few edges
   task automatic settle();
      repeat (4) @(posedge clk);
   endtask : settle

   task automatic testReset();
      check("gio oe", gOe, '0);
      check("oe", 96'({tOe, starOe, rOe, lOe}), '0);
      check("gio out", gOut, '0);
      check("out", 96'({tOut, starOut, rOut, lOut}), '0);
      rdChk("dir0", `OFS_GIO_DIR0, '1, `DIR_RESET, `RESP_OKAY);
      wr(12'h100, 32'h1234_5678, 4'hf, `RESP_SLVERR);
      rdChk("hole", 12'h100, '1, 32'h0000_0000, `RESP_SLVERR);
      $display("reset test done");
   endtask : testReset

   // Mixed directions in one port; partner drives the input lines and yields on output lines
   task automatic testGio();
      farDrv <= {96'h8000_0000_0000_0000_0000_00ff, 35'h0};
      farVal <= {96'h8000_0000_0000_0000_0000_00a5, 35'h0};
      wr(`OFS_GIO_DIR0, 32'h0000_00f0, 4'hf, `RESP_OKAY);
      wr(`OFS_GIO_DIR2, 32'h4000_0001, 4'hf, `RESP_OKAY);
      wr(`OFS_GIO_OUT0, 32'h0000_00a0, 4'hf, `RESP_OKAY);
      wr(`OFS_GIO_OUT2, 32'hffff_ffff, 4'hf, `RESP_OKAY);
      wr(`OFS_GIO_OUT0, 32'hffff_ff5a, 4'h1, `RESP_OKAY);
      wr(`OFS_GIO_IN0, 32'hffff_ffff, 4'hf, `RESP_OKAY);
      settle();
      check("gio oe", gOe, 96'h4000_0001_0000_0000_0000_00f0);
      check("gio out", gOut, 96'h4000_0001_0000_0000_0000_0050);
      rdChk("out0", `OFS_GIO_OUT0, '1, 32'h0000_005a, `RESP_OKAY);
      rdChk("in0", `OFS_GIO_IN0, 32'hff, 32'h0000_0055, `RESP_OKAY);
      rdChk("in2", `OFS_GIO_IN2, 32'hc000_0001, 32'hc000_0001,
            `RESP_OKAY);
      $display("general line test done");
   endtask : testGio

   // Star stays off until the backplane variant is chosen
   task automatic testTrig();
      farDrv[34:26] <= 9'h1ff;
      farVal[34:26] <= 9'h154;
      wr(`OFS_TRIG_CTL, 32'h0300_0181, 4'hf, `RESP_OKAY);
      settle();
      check("trig oe", 96'(tOe), 96'h81);
      check("trig out", 96'(tOut), 96'h01);
      check("star off", 96'(starOe), 96'h0);
      rdChk("trig in", `OFS_LINE_IN, 32'h08ff, 32'h002b,
            `RESP_OKAY);
      wr(`OFS_CONFIG, 32'h0000_0003, 4'hf, `RESP_OKAY);
      settle();
      check("star", 96'({starOe, starOut}), 96'h3);
      rdChk("config", `OFS_CONFIG, '1, 32'h0000_0003, `RESP_OKAY);
      rdChk("star in", `OFS_LINE_IN, 32'h0800_0000, 32'h0800_0000,
            `RESP_OKAY);
      $display("trigger test done");
   endtask : testTrig

   // Local buses, then a reset in mid-run with lines driven
   task automatic testLb();
      farDrv[25:0] <= '1;
      farVal[25:0] <= {13'h0555, 13'h1fff};
      wr(`OFS_LB_DIR, 32'h0fff_1001, 4'hf, `RESP_OKAY);
      wr(`OFS_LB_OUT, 32'h0aaa_1000, 4'hf, `RESP_OKAY);
      settle();
      check("lb oe", 96'({rOe, lOe}), 96'({13'h1001, 13'h0fff}));
      check("lb out", 96'({rOut, lOut}),
            96'({13'h1000, 13'h0aaa}));
      rdChk("lb in", `OFS_LINE_IN, 32'h07ff_ff00, 32'h0555_2a00,
            `RESP_OKAY);
      rstn <= 1'b0;
      @(posedge clk);
      check("rst gio oe", gOe, '0);
      check("rst oe", 96'({tOe, starOe, rOe, lOe}), '0);
      rstn <= 1'b1;
      rdChk("lb dir", `OFS_LB_DIR, '1, `DIR_RESET, `RESP_OKAY);
      $display("local bus test done");
   endtask : testLb

   // Clock enable low freezes the input flops; a stale level shows first
   task automatic testHold();
      @(posedge clk);
      ce <= 1'b0;
      farVal[35] <= 1'b0;
      repeat (4) @(posedge clk);
      ce <= 1'b1;
      rdChk("frozen", `OFS_GIO_IN0, 32'h1, 32'h1, `RESP_OKAY);
      rdChk("thawed", `OFS_GIO_IN0, 32'h1, 32'h0, `RESP_OKAY);
      $display("clock enable test done");
   endtask : testHold

   // Every input has a value at time zero; reset held two cycles
   initial begin
      nErrors = 0;
      testsRun = 0;
      rstn = 1'b0;
      ce = 1'b1;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      farDrv = '0;
      farVal = '0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      testReset();
      testGio();
      testTrig();
      testLb();
      testHold();
      testDone();
   end
endmodule : io_and_trigger_line_direction_tb_top
